// ### common/sbl_pkg.sv
// Shared constants and types for the serial boot loader.
// Assumes a single 100 MHz clock domain.
package sbl_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ           = 100_000_000;
	localparam int MIN_BOOT_HZ      = 2_000_000;
	localparam int MAX_BOOT_HZ      = 13_500_000;
	localparam int START_DELAY_CYC  = 100;
	localparam int CAPTURE_CYC      = 3;
	localparam int BITS_PER_MEASURE = 9;
	// ----------------------------------------
	// Register map and fields
	// ----------------------------------------
	localparam logic [11:0] A_GATE     = 12'h000;
	localparam logic [11:0] A_STAT     = 12'h004;
	localparam logic [11:0] A_DIV      = 12'h008;
	localparam logic [11:0] A_LEN      = 12'h00c;
	localparam logic [11:0] A_RAM      = 12'h400;
	localparam logic [7:0]  GATE_RST   = 8'h00;
	localparam int          SEL_BIT    = 3;
	localparam logic [23:0] FREG_LO    = 24'hffffa8;
	localparam logic [23:0] FREG_HI    = 24'hffffac;
	localparam logic [23:0] PROG_START = 24'hffc000;
	// ----------------------------------------
	// Link bytes and pin codes
	// ----------------------------------------
	localparam logic [7:0] ACK_BYTE  = 8'h00;
	localparam logic [7:0] HOST_OK   = 8'h55;
	localparam logic [7:0] ERASE_ERR = 8'hff;
	localparam logic [2:0] MD_BOOT_X = 3'h2;
	localparam logic [2:0] MD_BOOT_S = 3'h3;
	localparam logic [2:0] MD_USER_X = 3'h6;
	localparam logic [2:0] MD_USER_S = 3'h7;
	typedef enum logic [1:0] {SBL_NORMAL, SBL_BOOT, SBL_USER} sbl_mode_type;
	typedef enum logic [3:0] {ST_RESET, ST_NORMAL, ST_START, ST_MEASURE, ST_ACK,
		ST_WAIT55, ST_CHECK, ST_ERASE, ST_LEN_HI, ST_LEN_LO, ST_LOAD, ST_ERR,
		ST_HALT, ST_RUN} sbl_state_type;
	typedef struct packed {
		logic [22:0] zero;
		logic [3:0]  state;
		logic        clk_ok;
		logic        halted;
		logic        ram_rsv;
		logic [1:0]  mode;
	} sbl_status_type;
endpackage

// ### common/sbl_ser_if.sv
// Link between the boot sequencer and its serial channel.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sbl_ser_if #(parameter int DIV_W = 20);
	logic [DIV_W-1:0] divisor;
	logic             rx_en;
	logic             tx_en;
	logic             rx_line;
	logic             tx_line;
	logic             tx_valid;
	logic             tx_ready;
	logic [7:0]       tx_data;
	logic             rx_valid;
	logic             rx_err;
	logic [7:0]       rx_data;
	modport ctrl (output divisor, rx_en, tx_en, rx_line, tx_valid, tx_data,
		input tx_line, tx_ready, rx_valid, rx_err, rx_data);
	modport chan (input divisor, rx_en, tx_en, rx_line, tx_valid, tx_data,
		output tx_line, tx_ready, rx_valid, rx_err, rx_data);
endinterface
`default_nettype wire

// ### design/sbl_rate_meter.sv
// Measures the low run of one all-zero frame and derives the bit period.
// Assumes rx_in is already synchronised.
`timescale 1ns/1ps
`default_nettype none
module sbl_rate_meter #(parameter int CNT_W = 20) (
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             start_in,
	input  wire logic             rx_in,
	output logic                  done_out,
	output logic [CNT_W-1:0]      divisor_out
);
	typedef enum logic [1:0] {M_IDLE, M_HIGH, M_LOW} sbl_meter_type;
	sbl_meter_type    state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt, next_div, quot;
	logic             next_done;

	assign quot = cnt / CNT_W'(sbl_pkg::BITS_PER_MEASURE);

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_div = divisor_out;
		next_done = 1'b0;
		case (state)
			M_IDLE: if (start_in && rx_in) next_state = M_HIGH;
			M_HIGH: if (!rx_in) begin
				next_cnt = CNT_W'(1);
				next_state = M_LOW;
			end
			M_LOW: if (rx_in) begin
				// Start plus eight zero bits, so the run is nine bits
				next_div = quot;
				next_done = (quot != '0);
				next_state = (quot != '0) ? M_IDLE : M_HIGH;
			end else if (cnt != '1) begin
				next_cnt = cnt + CNT_W'(1);
			end
			default: next_state = M_IDLE;
		endcase
		if (!start_in) next_state = M_IDLE;
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= M_IDLE;
			cnt <= '0;
			divisor_out <= '0;
			done_out <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			divisor_out <= next_div;
			done_out <= next_done;
		end
	end

	div_nine_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		done_out |-> divisor_out == $past(cnt) / CNT_W'(9) && divisor_out != '0)
		else $error("divisor is not a ninth of the low run");
endmodule
`default_nettype wire

// ### design/sbl_uart.sv
// Asynchronous serial channel, 8 data bits, 1 stop bit, no parity.
// Assumes rx_line is synchronised and divisor is at least two.
`timescale 1ns/1ps
`default_nettype none
module sbl_uart #(parameter int DIV_W = 20) (
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	sbl_ser_if.chan   ser
);
	typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} sbl_rx_type;
	sbl_rx_type       rst_q, next_rst;
	logic [DIV_W-1:0] rcnt, next_rcnt, tcnt, next_tcnt;
	logic [2:0]       rbit, next_rbit;
	logic [7:0]       rsh, next_rsh;
	logic             rvld, next_rvld, rerr, next_rerr, busy, next_busy;
	logic [9:0]       tsh, next_tsh;
	logic [3:0]       tbit, next_tbit;

	assign ser.rx_valid = rvld;
	assign ser.rx_err = rerr;
	assign ser.rx_data = rsh;
	assign ser.tx_ready = ser.tx_en && !busy;
	assign ser.tx_line = busy ? tsh[0] : 1'b1;

	always_comb begin
		next_rst = rst_q;
		next_rcnt = (rcnt != '0) ? rcnt - DIV_W'(1) : rcnt;
		next_rbit = rbit;
		next_rsh = rsh;
		next_rvld = 1'b0;
		next_rerr = 1'b0;
		// Frame is fixed to the asynchronous format
		case (rst_q)
			R_IDLE: if (!ser.rx_line) begin
				next_rcnt = ser.divisor >> 1;
				next_rst = R_START;
			end
			R_START: if (rcnt == '0) begin
				next_rcnt = ser.divisor - DIV_W'(1);
				next_rbit = 3'h0;
				next_rst = ser.rx_line ? R_IDLE : R_DATA;
			end
			R_DATA: if (rcnt == '0) begin
				next_rsh = {ser.rx_line, rsh[7:1]};
				next_rcnt = ser.divisor - DIV_W'(1);
				next_rbit = rbit + 3'h1;
				if (rbit == 3'h7) next_rst = R_STOP;
			end
			R_STOP: if (rcnt == '0) begin
				next_rvld = ser.rx_line;
				next_rerr = !ser.rx_line;
				next_rst = R_IDLE;
			end
			default: next_rst = R_IDLE;
		endcase
		if (!ser.rx_en) next_rst = R_IDLE;
		next_busy = busy;
		next_tsh = tsh;
		next_tbit = tbit;
		next_tcnt = (tcnt != '0) ? tcnt - DIV_W'(1) : tcnt;
		if (!busy) begin
			if (ser.tx_en && ser.tx_valid) begin
				next_tsh = {1'b1, ser.tx_data, 1'b0};
				next_tbit = 4'h0;
				next_tcnt = ser.divisor - DIV_W'(1);
				next_busy = 1'b1;
			end
		end else if (tcnt == '0) begin
			next_tsh = {1'b1, tsh[9:1]};
			next_tbit = tbit + 4'h1;
			next_tcnt = ser.divisor - DIV_W'(1);
			if (tbit == 4'h9) next_busy = 1'b0;
		end
		// Disabling cuts a frame short; the loader never does so mid-byte
		if (!ser.tx_en) next_busy = 1'b0;
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_q <= R_IDLE;
			rcnt <= '0;
			rbit <= 3'h0;
			rsh <= 8'h00;
			rvld <= 1'b0;
			rerr <= 1'b0;
			busy <= 1'b0;
			tsh <= 10'h3ff;
			tbit <= 4'h0;
			tcnt <= '0;
		end else begin
			rst_q <= next_rst;
			rcnt <= next_rcnt;
			rbit <= next_rbit;
			rsh <= next_rsh;
			rvld <= next_rvld;
			rerr <= next_rerr;
			busy <= next_busy;
			tsh <= next_tsh;
			tbit <= next_tbit;
			tcnt <= next_tcnt;
		end
	end

	tx_start_low_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!busy && ser.tx_en && ser.tx_valid |=> busy && !ser.tx_line)
		else $error("frame does not open with a low start bit");
endmodule
`default_nettype wire

// ### design/sbl_top.sv
// Serial boot loader: mode entry, bit rate adjustment, program load, flash gate.
// Assumes an AHB-Lite master, a flash array on the same clock, pins asynchronous.
//
// Behaviour
// - Flash access gate is 8 bits, cleared on any reset and standby.
// - Gate bit 3 selects flash control registers at 0xFFFFA8..0xFFFFAC.
// - Write-enable high with mode 010/011 is boot, 110/111 user program.
// - Programming state entered only by reset-start in a programming mode.
// - Boot loads host program into RAM program area, then branches there.
// - Host sends 0x00 bytes, 8N1; device measures their low period.
// - Device sends 0x00 after adjustment; host answers with 0x55.
// - Rate adjustment supported only for clocks 2 to 13.5 MHz; the code adjusts at any clock and only flags the range in status clk_ok.
// - Unerasable cell: send 0xFF once and halt everything after.
// - Measurement starts about 100 cycles after reset release.
// - Flash holding any programmed data is fully erased before loading.
// - Before branch: serial disabled, divisor kept, transmit pin high.
// - Boot RAM area stays reserved until the loaded program runs.
// - Boot ends only by reset with new pins, or watchdog overflow; here a watchdog restart relatches pins, re-entering boot if still selected.
// - Interrupts are blocked while flash programs or erases.
// - Loading channel runs in asynchronous mode.
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module sbl_top #(
	parameter int CLK_HZ    = sbl_pkg::CLK_HZ,
	parameter int DIV_W     = 20,
	parameter int RAM_DEPTH = 256
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic [31:0]      hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	input  wire logic        flash_write_enable_pin_in,
	input  wire logic        mode_pin_2_in,
	input  wire logic        mode_pin_1_in,
	input  wire logic        mode_pin_0_in,
	input  wire logic        standby_b_in,
	input  wire logic        watchdog_overflow_in,
	input  wire logic        serial_rx_pin_in,
	output logic             serial_tx_pin_out,
	input  wire logic [23:0] cpu_addr_in,
	output logic             flash_ctrl_sel_out,
	input  wire logic        flash_blank_in,
	output logic             erase_all_out,
	input  wire logic        erase_done_in,
	input  wire logic        erase_fail_in,
	input  wire logic        flash_busy_in,
	output logic             irq_block_out,
	output logic             prog_state_out,
	output logic             boot_mode_out,
	output logic             branch_out,
	output logic [23:0]      branch_addr_out,
	output logic             ram_reserved_out
);
	localparam int  AW     = $clog2(RAM_DEPTH);
	localparam logic CLK_OK = (CLK_HZ >= sbl_pkg::MIN_BOOT_HZ) &&
		(CLK_HZ <= sbl_pkg::MAX_BOOT_HZ);

	sbl_ser_if #(.DIV_W(DIV_W)) ser ();
	sbl_pkg::sbl_state_type state, next_state;
	sbl_pkg::sbl_mode_type  mode, next_mode, pin_mode;
	sbl_pkg::sbl_status_type stat;
	logic [5:0]       pin_s1, pin_s2;
	logic [7:0]       cnt, next_cnt, gate, next_gate;
	logic [15:0]      prog_len, next_len, load_idx, next_idx;
	logic [DIV_W-1:0] divisor, next_div, meas_div;
	logic             meas_done, next_erase, next_branch, tx_valid;
	logic [7:0]       tx_data;
	logic             wr_pend, next_wr;
	logic [11:0]      wr_addr, next_waddr;
	logic [31:0]      next_rdata;
	logic             addr_ok, rd_req;
	logic [7:0]       prog_ram [RAM_DEPTH];

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_s1 <= 6'h3f;
			pin_s2 <= 6'h3f;
		end else begin
			pin_s1 <= {standby_b_in, flash_write_enable_pin_in, mode_pin_2_in,
				mode_pin_1_in, mode_pin_0_in, serial_rx_pin_in};
			pin_s2 <= pin_s1;
		end
	end

	function automatic sbl_pkg::sbl_mode_type decode_mode(input logic flash_write_enable_pin,
		input logic [2:0] md);
		decode_mode = sbl_pkg::SBL_NORMAL;
		if (flash_write_enable_pin && (md == sbl_pkg::MD_BOOT_X || md == sbl_pkg::MD_BOOT_S))
			decode_mode = sbl_pkg::SBL_BOOT;
		if (flash_write_enable_pin && (md == sbl_pkg::MD_USER_X || md == sbl_pkg::MD_USER_S))
			decode_mode = sbl_pkg::SBL_USER;
	endfunction

	assign pin_mode = decode_mode(pin_s2[4], pin_s2[3:1]);

	// ----------------------------------------
	// Serial channel and rate meter
	// ----------------------------------------
	assign ser.divisor = divisor; // Divisor survives the branch
	assign ser.rx_line = pin_s2[0];
	assign ser.rx_en = state inside {sbl_pkg::ST_WAIT55, sbl_pkg::ST_CHECK,
		sbl_pkg::ST_ERASE, sbl_pkg::ST_LEN_HI, sbl_pkg::ST_LEN_LO, sbl_pkg::ST_LOAD};
	// Halt keeps transmit on so the error byte finishes
	assign ser.tx_en = ser.rx_en || state inside {sbl_pkg::ST_ACK,
		sbl_pkg::ST_ERR, sbl_pkg::ST_HALT};
	assign ser.tx_valid = tx_valid;
	assign ser.tx_data = tx_data;

	sbl_uart #(.DIV_W(DIV_W)) u_uart (
		.clk_in  (clk_in),
		.rst_b_in(rst_b_in),
		.ser     (ser)
	);

	sbl_rate_meter #(.CNT_W(DIV_W)) u_meter (
		.clk_in     (clk_in),
		.rst_b_in   (rst_b_in),
		.start_in   (state == sbl_pkg::ST_MEASURE),
		.rx_in      (pin_s2[0]),
		.done_out   (meas_done),
		.divisor_out(meas_div)
	);

	// ----------------------------------------
	// Boot sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_mode = mode;
		next_len = prog_len;
		next_idx = load_idx;
		next_div = divisor;
		next_erase = 1'b0;
		next_branch = 1'b0;
		tx_valid = 1'b0;
		tx_data = sbl_pkg::ACK_BYTE;
		if (cnt != 8'(sbl_pkg::START_DELAY_CYC)) next_cnt = cnt + 8'h01;
		case (state)
			sbl_pkg::ST_RESET: if (cnt == 8'(sbl_pkg::CAPTURE_CYC)) begin
				// Mode only latched at reset-start
				next_mode = pin_mode;
				next_state = (pin_mode == sbl_pkg::SBL_BOOT) ? sbl_pkg::ST_START :
					sbl_pkg::ST_NORMAL;
			end
			sbl_pkg::ST_NORMAL: next_state = state;
			sbl_pkg::ST_START: if (cnt == 8'(sbl_pkg::START_DELAY_CYC))
				next_state = sbl_pkg::ST_MEASURE;
			sbl_pkg::ST_MEASURE: if (meas_done) begin
				next_div = meas_div;
				next_state = sbl_pkg::ST_ACK;
			end
			sbl_pkg::ST_ACK: begin
				tx_valid = 1'b1;
				if (ser.tx_ready) next_state = sbl_pkg::ST_WAIT55;
			end
			// Stray zero bytes from the host are ignored here
			sbl_pkg::ST_WAIT55: if (ser.rx_valid && ser.rx_data == sbl_pkg::HOST_OK)
				next_state = sbl_pkg::ST_CHECK;
			sbl_pkg::ST_CHECK: if (flash_blank_in) begin
				next_state = sbl_pkg::ST_LEN_HI;
			end else begin
				next_erase = 1'b1;
				next_state = sbl_pkg::ST_ERASE;
			end
			sbl_pkg::ST_ERASE: if (erase_fail_in) begin
				next_state = sbl_pkg::ST_ERR;
			end else if (erase_done_in) begin
				next_state = sbl_pkg::ST_LEN_HI;
			end
			sbl_pkg::ST_LEN_HI: if (ser.rx_valid) begin
				next_len = {ser.rx_data, prog_len[7:0]};
				next_state = sbl_pkg::ST_LEN_LO;
			end
			sbl_pkg::ST_LEN_LO: if (ser.rx_valid) begin
				next_len = {prog_len[15:8], ser.rx_data};
				next_idx = 16'h0000;
				next_branch = (next_len == 16'h0000);
				next_state = next_branch ? sbl_pkg::ST_RUN : sbl_pkg::ST_LOAD;
			end
			sbl_pkg::ST_LOAD: if (ser.rx_valid) begin
				next_idx = load_idx + 16'h0001;
				if (next_idx == prog_len) begin
					next_branch = 1'b1;
					next_state = sbl_pkg::ST_RUN;
				end
			end
			sbl_pkg::ST_ERR: begin
				tx_valid = 1'b1;
				tx_data = sbl_pkg::ERASE_ERR;
				if (ser.tx_ready) next_state = sbl_pkg::ST_HALT;
			end
			sbl_pkg::ST_HALT: next_state = state;
			sbl_pkg::ST_RUN: next_state = state;
			default: next_state = sbl_pkg::ST_RESET;
		endcase
		if (watchdog_overflow_in) begin
			next_state = sbl_pkg::ST_RESET;
			next_cnt = 8'h00;
			next_mode = sbl_pkg::SBL_NORMAL;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= sbl_pkg::ST_RESET;
			cnt <= 8'h00;
			mode <= sbl_pkg::SBL_NORMAL;
			prog_len <= 16'h0000;
			load_idx <= 16'h0000;
			divisor <= '0;
			erase_all_out <= 1'b0;
			branch_out <= 1'b0;
			branch_addr_out <= sbl_pkg::PROG_START;
			boot_mode_out <= 1'b0;
			prog_state_out <= 1'b0;
			ram_reserved_out <= 1'b0;
			irq_block_out <= 1'b0;
			serial_tx_pin_out <= 1'b1;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			mode <= next_mode;
			prog_len <= next_len;
			load_idx <= next_idx;
			divisor <= next_div;
			erase_all_out <= next_erase;
			branch_out <= next_branch;
			branch_addr_out <= sbl_pkg::PROG_START;
			boot_mode_out <= next_mode == sbl_pkg::SBL_BOOT;
			prog_state_out <= next_mode != sbl_pkg::SBL_NORMAL;
			ram_reserved_out <= next_mode == sbl_pkg::SBL_BOOT &&
				next_state != sbl_pkg::ST_RUN;
			// Cycle after the last erase cycle stays covered too, the flash may still be settling
			irq_block_out <= flash_busy_in || state == sbl_pkg::ST_ERASE ||
				next_state == sbl_pkg::ST_ERASE;
			serial_tx_pin_out <= (next_state == sbl_pkg::ST_RUN) ? 1'b1 :
				ser.tx_line;
		end
	end

	// Bytes past the RAM depth are counted but dropped
	always_ff @(posedge clk_in) begin
		if (state == sbl_pkg::ST_LOAD && ser.rx_valid && load_idx < 16'(RAM_DEPTH))
			prog_ram[load_idx[AW-1:0]] <= ser.rx_data;
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	assign addr_ok = hsel_in && htrans_in[1] && hready_in;
	assign rd_req = addr_ok && !hwrite_in;

	always_comb begin
		next_wr = addr_ok && hwrite_in;
		next_waddr = haddr_in[11:0];
		next_gate = gate;
		if (wr_pend && wr_addr == sbl_pkg::A_GATE)
			next_gate = hwdata_in[7:0];
		if (!pin_s2[5] || watchdog_overflow_in) next_gate = sbl_pkg::GATE_RST;
		stat = '0;
		stat.state = 4'(state);
		stat.clk_ok = CLK_OK;
		stat.halted = state == sbl_pkg::ST_HALT;
		stat.ram_rsv = ram_reserved_out;
		stat.mode = 2'(mode);
		next_rdata = 32'h0000_0000;
		if (rd_req) begin
			if (haddr_in[11:10] == sbl_pkg::A_RAM[11:10]) begin
				if (32'(haddr_in[9:2]) < RAM_DEPTH)
					next_rdata = {24'h00_0000, prog_ram[haddr_in[AW+1:2]]};
			end else begin
				case (haddr_in[11:0])
					sbl_pkg::A_GATE: next_rdata = {24'h00_0000, next_gate};
					sbl_pkg::A_STAT: next_rdata = stat;
					sbl_pkg::A_DIV:  next_rdata = 32'(divisor);
					sbl_pkg::A_LEN:  next_rdata = {16'h0000, prog_len};
					default:         next_rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gate <= sbl_pkg::GATE_RST;
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			hrdata_out <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			flash_ctrl_sel_out <= 1'b0;
		end else begin
			gate <= next_gate;
			wr_pend <= next_wr;
			wr_addr <= next_waddr;
			hrdata_out <= next_rdata;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			flash_ctrl_sel_out <= next_gate[sbl_pkg::SEL_BIT] &&
				cpu_addr_in >= sbl_pkg::FREG_LO && cpu_addr_in <= sbl_pkg::FREG_HI;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	gate_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!pin_s2[5] |=> gate == 8'h00 && !flash_ctrl_sel_out)
		else $error("gate not cleared in standby");
	sel_window_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		flash_ctrl_sel_out |-> $past(cpu_addr_in) >= 24'hffffa8 &&
			$past(cpu_addr_in) <= 24'hffffac && gate[3])
		else $error("flash registers selected outside window");
	boot_decode_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		state == sbl_pkg::ST_RESET && cnt == 8'd3 && pin_s2[4] && pin_s2[3:1] == 3'b011
		|=> state == sbl_pkg::ST_START ##1 boot_mode_out && prog_state_out)
		else $error("boot pins not decoded as boot");
	start_delay_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$rose(state == sbl_pkg::ST_MEASURE) |-> cnt == 8'd100)
		else $error("measurement began before the start delay");
	ack_first_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$rose(state == sbl_pkg::ST_WAIT55) |-> $past(state) == sbl_pkg::ST_ACK &&
			$past(ser.tx_data) == 8'h00)
		else $error("answer awaited without adjustment byte");
	halt_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		state == sbl_pkg::ST_HALT && !watchdog_overflow_in |=>
			state == sbl_pkg::ST_HALT && !erase_all_out && !branch_out)
		else $error("operation resumed after erase error");
	branch_clean_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		branch_out |-> !ser.rx_en && !ser.tx_en && serial_tx_pin_out &&
			branch_addr_out == 24'hffc000 && divisor == $past(divisor, 2))
		else $error("branch without quiet serial channel");
	irq_block_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		flash_busy_in || state == sbl_pkg::ST_ERASE |=> irq_block_out)
		else $error("interrupts open during flash operation");
	wdt_exit_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		watchdog_overflow_in |=> state == sbl_pkg::ST_RESET && !boot_mode_out)
		else $error("watchdog did not end boot");
endmodule
`default_nettype wire

// ### test/sbl_host.sv
// Host model on the boot link: 8N1 sender and receiver, LSB first.
// Assumes a bit time in clock cycles; the line idles high as if pulled up.
`timescale 1ns/1ps
`default_nettype none
module sbl_host #(parameter int BIT = 20) (
	input  wire logic clk_in,
	input  wire logic rx_in,
	output logic      tx_out
);
	// ----------------------------------------
	// Link tasks
	// ----------------------------------------
	initial tx_out = 1'b1; // Line high when reset ends
	task automatic send(input logic [7:0] b); // Start, 8 data, 1 stop, no parity
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_in);
			tx_out <= f[i];
			repeat (BIT - 1) @(posedge clk_in);
		end
	endtask
	task automatic recv(output logic [7:0] b); // Returns in the middle of the stop bit, before any reply
		@(negedge rx_in);
		repeat (BIT / 2) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk_in);
			b[i] = rx_in;
		end
		repeat (BIT) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
// Testbench for the serial boot loader: bus, mode pins and boot link.
// Assumes the host model on the serial pins and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int BIT = 20; // Host bit time in cycles, scaled down for run length
	logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, flash_write_enable_pin = 1'b0;
	logic        stby_b = 1'b1, wdog = 1'b0, e_done = 1'b0, e_fail = 1'b0, busy = 1'b0;
	logic        hready, rxd, txd, sel, erase, irq, prog, boot, br, rsv, hresp, blank = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  md = 3'h0, hsize = 3'h0;
	logic [23:0] cpu_addr = 24'h0, br_addr;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [23:0] win [4] = '{24'hffffa8, 24'hffffac, 24'hffffa4, 24'hffffb0};
	int          fail_count = 0, checks = 0, cyc = 0;
	sbl_top u_sbl_top (
		.clk_in(clk), .rst_b_in(rst_b), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.flash_write_enable_pin_in(flash_write_enable_pin), .mode_pin_2_in(md[2]), .mode_pin_1_in(md[1]),
		.mode_pin_0_in(md[0]), .standby_b_in(stby_b), .watchdog_overflow_in(wdog),
		.serial_rx_pin_in(rxd), .serial_tx_pin_out(txd), .cpu_addr_in(cpu_addr),
		.flash_ctrl_sel_out(sel), .flash_blank_in(blank), .erase_all_out(erase),
		.erase_done_in(e_done), .erase_fail_in(e_fail), .flash_busy_in(busy),
		.irq_block_out(irq), .prog_state_out(prog), .boot_mode_out(boot),
		.branch_out(br), .branch_addr_out(br_addr), .ram_reserved_out(rsv)
	);
	sbl_host #(.BIT(BIT)) u_sbl_host (.clk_in(clk), .rx_in(txd), .tx_out(rxd));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		{hsel, htrans, hwrite, hsize, haddr} <= {1'b1, 2'h2, w, 3'h2, 20'h0, a};
		@(posedge clk iff hready === 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		@(posedge clk iff hready === 1'b1);
		r = hrdata;
	endtask
	task rst(input logic [3:0] p);
		@(posedge clk);
		rst_b <= 1'b0;
		{flash_write_enable_pin, md} <= p; // Pins then held steady
		repeat (20) @(posedge clk); // Long enough to leave boot
		rst_b <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
	task test_done;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		logic [31:0] r;
		ahb(1'b0, sbl_pkg::A_GATE, 32'h0, r);
		chk("gate reset", 32'h0, r);
		ahb(1'b1, sbl_pkg::A_GATE, 32'h8, r); // Only the select bit set
		ahb(1'b0, sbl_pkg::A_GATE, 32'h0, r);
		chk("gate", 32'h8, r);
		foreach (win[i]) begin
			@(posedge clk);
			cpu_addr <= win[i];
			repeat (2) @(posedge clk);
			chk("select", 32'(i < 2), 32'(sel));
		end
		busy <= 1'b1;
		repeat (2) @(posedge clk);
		chk("irq block", 32'h1, 32'(irq));
		busy <= 1'b0;
		ahb(1'b0, 12'h100, 32'h0, r);
		chk("unmapped", 32'h0, r);
		chk("hresp", 32'h0, 32'(hresp));
		stby_b <= 1'b0;
		repeat (5) @(posedge clk);
		stby_b <= 1'b1;
		ahb(1'b0, sbl_pkg::A_GATE, 32'h0, r);
		chk("gate standby", 32'h0, r);
	endtask
	task t_modes;
		logic [3:0] pin [6] = '{4'ha, 4'hb, 4'he, 4'hf, 4'h3, 4'h9};
		logic [1:0] want [6] = '{2'h3, 2'h3, 2'h2, 2'h2, 2'h0, 2'h0};
		foreach (pin[i]) begin
			rst(pin[i]);
			chk("prog boot", 32'(want[i]), 32'({prog, boot}));
		end
	endtask
	task t_boot(input logic f, input logic bl);
		logic [31:0] r;
		logic [7:0]  b;
		blank <= bl;
		rst(4'hb); // Boot restarted through reset on every run
		repeat (150) @(posedge clk); // Wait past the measurement arm point
		fork
			u_sbl_host.send(8'h00);
			u_sbl_host.recv(b);
		join
		chk("ack", 32'h0, 32'(b));
		ahb(1'b0, sbl_pkg::A_DIV, 32'h0, r);
		chk("divisor", 32'(BIT), r);
		chk("reserved", 32'h1, 32'(rsv));
		fork
			u_sbl_host.send(sbl_pkg::HOST_OK);
			if (!bl) @(posedge clk iff erase === 1'b1); // Flash not blank, so erased first
		join
		ahb(1'b0, sbl_pkg::A_STAT, 32'h0, r);
		chk("erase state", bl ? 32'h8 : 32'h7, 32'(r[8:5]));
		if (!bl) begin
			chk("irq erase", 32'h1, 32'(irq));
			@(posedge clk);
			{e_fail, e_done} <= {f, !f};
			@(posedge clk);
			{e_fail, e_done} <= 2'h0;
		end
		if (f) begin
			u_sbl_host.recv(b);
			chk("erase error", 32'hff, 32'(b));
			ahb(1'b0, sbl_pkg::A_STAT, 32'h0, r);
			chk("halted", 32'h1, 32'(r[3]));
			chk("clock range", 32'h0, 32'(r[4]));
			wdog <= 1'b1;
			@(posedge clk);
			wdog <= 1'b0;
			repeat (10) @(posedge clk);
			ahb(1'b0, sbl_pkg::A_STAT, 32'h0, r);
			chk("halt cleared", 32'h0, 32'(r[3]));
		end else begin
			u_sbl_host.send(8'h00);
			u_sbl_host.send(8'h02);
			u_sbl_host.send(8'ha5);
			fork
				u_sbl_host.send(8'h3c);
				@(posedge clk iff br === 1'b1);
			join
			chk("branch addr", 32'(sbl_pkg::PROG_START), 32'(br_addr));
			chk("tx high", 32'h1, 32'(txd));
			chk("released", 32'h0, 32'(rsv));
			ahb(1'b0, sbl_pkg::A_DIV, 32'h0, r);
			chk("divisor kept", 32'(BIT), r);
			ahb(1'b0, sbl_pkg::A_RAM + 12'h4, 32'h0, r);
			chk("ram", 32'h3c, r);
		end
	endtask
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			test_done;
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		t_regs;
		t_modes;
		t_boot(1'b0, 1'b0);
		t_boot(1'b1, 1'b0);
		t_boot(1'b0, 1'b1);
		test_done;
	end
endmodule
`default_nettype wire
